/* File: logic/pbcd_defines.svh */
// Offsets, field positions and reset values of the PLL boot configuration decoder.
`ifndef PBCD_DEFINES_SVH
`define PBCD_DEFINES_SVH
`define PBCD_OFF_CFG_WORD 8'h00
`define PBCD_OFF_DECODED 8'h04
`define PBCD_OFF_STATUS 8'h08
`define PBCD_RSVD_MASK 32'hbff8_8000
`define PBCD_BIT_USB_FSEL 30
`define PBCD_ODIV_LSB 16
`define PBCD_MULT_LSB 8
`define PBCD_BIT_SRC 7
`define PBCD_RNG_LSB 4
`define PBCD_IDIV_LSB 0
`define PBCD_RST_WORD 32'hffff_ffff
`define PBCD_RST_DIV 6'h02
`define PBCD_RST_MULT 8'h01
`endif

/* File: logic/pbcd_pkg.sv */
// Types shared by the PLL boot configuration decoder modules.
package pbcd_pkg;
    typedef enum logic [2:0] {
        PBCD_RNG_BYPASS = 3'h0,
        PBCD_RNG_5_10 = 3'h1,
        PBCD_RNG_8_16 = 3'h2,
        PBCD_RNG_13_26 = 3'h3,
        PBCD_RNG_21_42 = 3'h4,
        PBCD_RNG_34_64 = 3'h5,
        PBCD_RNG_RSVD6 = 3'h6,
        PBCD_RNG_RSVD7 = 3'h7
    } pbcd_range_e;
    typedef enum logic [1:0] {
        PBCD_ST_RESET = 2'h0,
        PBCD_ST_CAPTURE = 2'h1,
        PBCD_ST_HOLD = 2'h2
    } pbcd_state_e;
endpackage

/* File: logic/pbcd_decode_if.sv */
// Interface carrying the raw word into the field decoder and the decoded settings back.
`timescale 1ns/1ps
interface pbcd_decode_if;
    logic [31:0] word;
    logic usb_ref_24mhz;
    logic [5:0] out_divisor;
    logic [7:0] feedback_mult;
    logic src_internal_rc;
    logic [2:0] input_range;
    logic [2:0] input_divisor;
    logic range_reserved;
    logic rsvd_bits_bad;
    modport decoder (input word, output usb_ref_24mhz, out_divisor, feedback_mult,
        src_internal_rc, input_range, input_divisor, range_reserved, rsvd_bits_bad);
    modport user (output word, input usb_ref_24mhz, out_divisor, feedback_mult,
        src_internal_rc, input_range, input_divisor, range_reserved, rsvd_bits_bad);
endinterface

/* File: logic/pbcd_field_decoder.sv */
// Combinational decode of the boot configuration word fields.
`timescale 1ns/1ps
`include "pbcd_defines.svh"
module pbcd_field_decoder (
    pbcd_decode_if.decoder dec // Raw word in, decoded settings out.
);
    logic [2:0] odiv;
    always_comb begin
        odiv = dec.word[`PBCD_ODIV_LSB +: 3];
        dec.usb_ref_24mhz = dec.word[`PBCD_BIT_USB_FSEL]; // see RULE_02
        case (odiv) // see RULE_03
            3'h0, 3'h1: dec.out_divisor = 6'h02;
            3'h2: dec.out_divisor = 6'h04;
            3'h3: dec.out_divisor = 6'h08;
            3'h4: dec.out_divisor = 6'h10;
            default: dec.out_divisor = 6'h20;
        endcase
        dec.feedback_mult = {1'b0, dec.word[`PBCD_MULT_LSB +: 7]} + 8'h01; // see RULE_04
        dec.src_internal_rc = dec.word[`PBCD_BIT_SRC]; // see RULE_05
        dec.input_range = dec.word[`PBCD_RNG_LSB +: 3]; // see RULE_06
        dec.range_reserved = (dec.input_range == pbcd_pkg::PBCD_RNG_RSVD6) ||
            (dec.input_range == pbcd_pkg::PBCD_RNG_RSVD7); // see RULE_06
        dec.input_divisor = dec.word[`PBCD_IDIV_LSB +: 3];
        // A programmer that cleared a reserved bit is flagged, not corrected.
        dec.rsvd_bits_bad = (dec.word & `PBCD_RSVD_MASK) != `PBCD_RSVD_MASK; // see RULE_01
    end
endmodule // pbcd_field_decoder

/* File: logic/pbcd_top.sv */
// PLL boot configuration decoder: captures the word at reset release and holds decoded settings.
// Summary of operation
// RULE_01 - Reserved bits 31, 29-19, 15 programmed as ones.
// RULE_02 - Bit 30: one 24 MHz, zero 12 MHz.
// RULE_03 - Bits 18-16 pick output divisor 2..32.
// RULE_04 - Bits 14-8 plus one give multiplier.
// RULE_05 - Bit 7 picks fast RC or primary oscillator.
// RULE_06 - Bits 6-4 pick range; 110, 111 reserved.
// RULE_07 - Capture once after reset, hold until reset.
`timescale 1ns/1ps
`include "pbcd_defines.svh"
module pbcd_top (
    input wire logic clock, // 250 MHz system clock.
    input wire logic rstn, // Asynchronous reset, active low.
    input wire logic [31:0] cfg_word_pins, // Nonvolatile word, static from outside.
    input wire logic wb_cyc_i, // Wishbone cycle.
    input wire logic wb_stb_i, // Wishbone strobe.
    input wire logic wb_we_i, // Wishbone write enable.
    input wire logic [7:0] wb_adr_i, // Wishbone byte address.
    input wire logic [31:0] wb_dat_i, // Wishbone write data, ignored.
    input wire logic [3:0] wb_sel_i, // Wishbone byte selects.
    output logic [31:0] wb_dat_o, // Wishbone read data.
    output logic wb_ack_o, // Wishbone acknowledge.
    output logic wb_err_o, // Wishbone error for unmapped or write access.
    output logic cfg_valid, // Settings captured and stable.
    output logic usb_pll_ref_freq_select, // One for 24 MHz reference.
    output logic [5:0] sys_pll_output_divisor, // Output divide ratio.
    output logic [7:0] sys_pll_feedback_multiplier, // Feedback multiply factor.
    output logic sys_pll_source_select, // One for internal fast RC oscillator.
    output logic [2:0] sys_pll_input_range, // Input frequency range code.
    output logic [2:0] sys_pll_input_divisor, // Raw input divisor code.
    output logic cfg_range_reserved, // Range code is reserved.
    output logic cfg_rsvd_bits_bad // A reserved bit was found cleared.
);
    logic [31:0] sync1_q;
    logic [31:0] sync2_q;
    logic [31:0] sync1_d;
    logic [31:0] sync2_d;
    pbcd_pkg::pbcd_state_e state_q;
    pbcd_pkg::pbcd_state_e state_d;
    logic [31:0] word_q;
    logic [31:0] word_d;
    logic usb_q;
    logic usb_d;
    logic src_q;
    logic src_d;
    logic rres_q;
    logic rres_d;
    logic rbad_q;
    logic rbad_d;
    logic valid_q;
    logic valid_d;
    logic [5:0] odiv_q;
    logic [5:0] odiv_d;
    logic [7:0] mult_q;
    logic [7:0] mult_d;
    logic [2:0] rng_q;
    logic [2:0] rng_d;
    logic [2:0] idiv_q;
    logic [2:0] idiv_d;
    logic [31:0] rdat_q;
    logic [31:0] rdat_d;
    logic ack_q;
    logic ack_d;
    logic err_q;
    logic err_d;
    logic [31:0] decoded_view;
    logic [31:0] status_view;
    logic req;
    pbcd_decode_if dec_if ();

    // The pins come from outside the clock domain, so two flops guard them.
    always_comb begin
        sync1_d = cfg_word_pins;
        sync2_d = sync1_q;
    end
    // No reset on the synchroniser: it has to hold the pin level already when reset
    // lifts, because the capture two edges later would otherwise freeze the reset
    // value instead of the programmed word.
    always_ff @(posedge clock) begin
        sync1_q <= sync1_d;
        sync2_q <= sync2_d;
    end

    assign dec_if.word = word_q;
    pbcd_field_decoder u_decoder (
        .dec(dec_if)
    );

    // Capture takes the synchroniser output on the second edge after reset release, then freezes for good.
    always_comb begin
        state_d = state_q;
        word_d = word_q;
        valid_d = valid_q;
        case (state_q)
            pbcd_pkg::PBCD_ST_RESET: begin
                // One edge is spent here so the capture never races the reset release.
                state_d = pbcd_pkg::PBCD_ST_CAPTURE;
            end
            pbcd_pkg::PBCD_ST_CAPTURE: begin
                // Capture reads the second stage only; the first may still be settling.
                word_d = sync2_q; // see RULE_07
                state_d = pbcd_pkg::PBCD_ST_HOLD;
            end
            pbcd_pkg::PBCD_ST_HOLD: begin
                // HOLD has no exit: only a reset can leave it, which freezes the settings.
                valid_d = 1'b1; // see RULE_07
            end
            default: begin
                state_d = pbcd_pkg::PBCD_ST_RESET;
            end
        endcase
    end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_q <= pbcd_pkg::PBCD_ST_RESET;
            word_q <= `PBCD_RST_WORD;
            valid_q <= 1'b0;
        end else begin
            state_q <= state_d;
            word_q <= word_d;
            valid_q <= valid_d;
        end
    end

    // Decoded outputs are registered so each port comes from a flop.
    // During reset these hold their own reset values, then until capture the decode of the reset word, so users must wait for
    // cfg_valid before they trust any setting.
    always_comb begin
        usb_d = dec_if.usb_ref_24mhz;
        odiv_d = dec_if.out_divisor;
        mult_d = dec_if.feedback_mult;
        src_d = dec_if.src_internal_rc;
        rng_d = dec_if.input_range;
        idiv_d = dec_if.input_divisor;
        rres_d = dec_if.range_reserved;
        rbad_d = dec_if.rsvd_bits_bad;
    end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            usb_q <= 1'b1;
            odiv_q <= `PBCD_RST_DIV;
            mult_q <= `PBCD_RST_MULT;
            src_q <= 1'b0;
            rng_q <= 3'h0;
            idiv_q <= 3'h0;
            rres_q <= 1'b0;
            rbad_q <= 1'b0;
        end else begin
            usb_q <= usb_d;
            odiv_q <= odiv_d;
            mult_q <= mult_d;
            src_q <= src_d;
            rng_q <= rng_d;
            idiv_q <= idiv_d;
            rres_q <= rres_d;
            rbad_q <= rbad_d;
        end
    end

    // Registers are read only; writes and unmapped reads end with an error.
    // Ack and err are registered, so the answer comes one cycle after the request is taken;
    // the guard on ack_q and err_q keeps a strobe that is still held from being taken twice.
    assign req = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
    // Read layouts; gaps between fields read as zero.
    assign decoded_view = {8'h00, mult_q, 2'h0, odiv_q, 1'b0, idiv_q, 1'b0, rng_q};
    assign status_view = {26'h0, rbad_q, rres_q, src_q, usb_q, 1'b0, valid_q};
    always_comb begin
        rdat_d = 32'h0000_0000;
        ack_d = 1'b0;
        err_d = 1'b0;
        if (req) begin
            if (wb_we_i) begin
                err_d = 1'b1; // see RULE_07
            end else begin
                case (wb_adr_i)
                    `PBCD_OFF_CFG_WORD: begin
                        rdat_d = word_q;
                        ack_d = 1'b1;
                    end
                    `PBCD_OFF_DECODED: begin
                        rdat_d = decoded_view;
                        ack_d = 1'b1;
                    end
                    `PBCD_OFF_STATUS: begin
                        rdat_d = status_view;
                        ack_d = 1'b1;
                    end
                    default: begin
                        // Unmapped offsets answer with err and read as zero.
                        err_d = 1'b1;
                    end
                endcase
            end
        end
    end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rdat_q <= 32'h0000_0000;
            ack_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            rdat_q <= rdat_d;
            ack_q <= ack_d;
            err_q <= err_d;
        end
    end

    // Every output port is a flop; these assigns only rename.
    assign wb_dat_o = rdat_q;
    assign wb_ack_o = ack_q;
    assign wb_err_o = err_q;
    assign cfg_valid = valid_q;
    assign usb_pll_ref_freq_select = usb_q;
    assign sys_pll_output_divisor = odiv_q;
    assign sys_pll_feedback_multiplier = mult_q;
    assign sys_pll_source_select = src_q;
    assign sys_pll_input_range = rng_q;
    assign sys_pll_input_divisor = idiv_q;
    assign cfg_range_reserved = rres_q;
    assign cfg_rsvd_bits_bad = rbad_q;
endmodule // pbcd_top

/* File: tb/pbcd_chk.sv */
// Checker tying the decoded PLL settings to the boot word seen at capture.
`timescale 1ns/1ps
module pbcd_chk (
    input wire logic clock, // Clock.
    input wire logic rstn, // Reset, active low.
    input wire logic [31:0] cfg_word_pins, // Boot word pins.
    input wire logic wb_cyc_i, // Bus cycle.
    input wire logic wb_stb_i, // Bus strobe.
    input wire logic wb_we_i, // Bus write.
    input wire logic wb_ack_o, // Bus acknowledge.
    input wire logic wb_err_o, // Bus error.
    input wire logic cfg_valid, // Settings frozen.
    input wire logic usb_pll_ref_freq_select, // USB reference select.
    input wire logic [5:0] sys_pll_output_divisor, // Output divisor.
    input wire logic [7:0] sys_pll_feedback_multiplier, // Multiplier.
    input wire logic sys_pll_source_select, // Source select.
    input wire logic [2:0] sys_pll_input_range, // Range code.
    input wire logic cfg_range_reserved, // Reserved range flag.
    input wire logic cfg_rsvd_bits_bad // Reserved bit flag.
);
    logic [31:0] word_q;
    logic [31:0] word_d;
    logic [5:0] div_x;
    // Pins are trusted only before capture, so later pin changes cannot mask a hold fault.
    always_comb begin
        word_d = cfg_valid ? word_q : cfg_word_pins;
        if (word_q[18:16] == 3'h0) begin
            div_x = 6'h02;
        end else if (word_q[18:16] > 3'h5) begin
            div_x = 6'h20;
        end else begin
            div_x = 6'h01 << word_q[18:16];
        end
    end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) word_q <= 32'h0;
        else word_q <= word_d;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    sequence rel_s; $rose(rstn); endsequence
    sequence req_s; wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o; endsequence
    cap_time_a: assert property (rel_s |-> ##[1:4] cfg_valid)
        else $error("late capture");
    hold_set_a: assert property (cfg_valid |=> cfg_valid &&
        $stable({usb_pll_ref_freq_select, sys_pll_output_divisor, sys_pll_feedback_multiplier,
        sys_pll_source_select, sys_pll_input_range, cfg_range_reserved, cfg_rsvd_bits_bad}))
        else $error("settings moved");
    wr_refuse_a: assert property (req_s ##0 wb_we_i |=> wb_err_o && !wb_ack_o)
        else $error("write taken");
    usb_ref_a: assert property (cfg_valid |->
        usb_pll_ref_freq_select == word_q[30]) else $error("usb ref");
    out_div_a: assert property (cfg_valid |->
        sys_pll_output_divisor == div_x) else $error("divisor");
    fb_mult_a: assert property (cfg_valid |->
        sys_pll_feedback_multiplier == {1'b0, word_q[14:8]} + 8'h01) else $error("multiplier");
    src_sel_a: assert property (cfg_valid |->
        sys_pll_source_select == word_q[7]) else $error("source");
    in_range_a: assert property (cfg_valid |->
        sys_pll_input_range == word_q[6:4] && cfg_range_reserved == (word_q[6:5] == 2'h3))
        else $error("range");
    rsvd_flag_a: assert property (cfg_valid |->
        cfg_rsvd_bits_bad == ((word_q & 32'hbff8_8000) != 32'hbff8_8000))
        else $error("reserved flag");
endmodule // pbcd_chk
bind pbcd_top pbcd_chk chk (
    .clock,
    .rstn,
    .cfg_word_pins,
    .wb_cyc_i,
    .wb_stb_i,
    .wb_we_i,
    .wb_ack_o,
    .wb_err_o,
    .cfg_valid,
    .usb_pll_ref_freq_select,
    .sys_pll_output_divisor,
    .sys_pll_feedback_multiplier,
    .sys_pll_source_select,
    .sys_pll_input_range,
    .cfg_range_reserved,
    .cfg_rsvd_bits_bad
);

/* File: tb/pbcd_tb_top.sv */
// Testbench of the PLL boot configuration decoder.
`timescale 1ns/1ps
module pbcd_tb_top;
    logic clock, rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o, cfg_valid, a, e;
    logic usb_pll_ref_freq_select, sys_pll_source_select, cfg_range_reserved, cfg_rsvd_bits_bad;
    logic [31:0] cfg_word_pins, wb_dat_i, wb_dat_o, w, d;
    logic [7:0] wb_adr_i, sys_pll_feedback_multiplier, m;
    logic [3:0] wb_sel_i;
    logic [5:0] sys_pll_output_divisor, dv;
    logic [2:0] sys_pll_input_range, sys_pll_input_divisor;
    int error_cnt, tests_run, cycles;
    pbcd_top dut (.clock, .rstn, .cfg_word_pins, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .cfg_valid,
        .usb_pll_ref_freq_select, .sys_pll_output_divisor, .sys_pll_feedback_multiplier,
        .sys_pll_source_select, .sys_pll_input_range, .sys_pll_input_divisor,
        .cfg_range_reserved, .cfg_rsvd_bits_bad);
    task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Entered just after a rising edge; the old ack value is what the edge sampled.
    task automatic wb(input logic we, input logic [7:0] adr);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        do begin
            @(posedge clock);
        end while (!(wb_ack_o | wb_err_o));
        {a, e, d} = {wb_ack_o, wb_err_o, wb_dat_o};
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clock);
    endtask
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles > 5000) begin
            error_cnt++;
            end_sim();
        end
    end
    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i} <= 11'h000;
        {wb_sel_i, wb_dat_i} <= {4'hf, 32'hffff_ffff};
        {error_cnt, tests_run, cycles} = 0;
        for (int i = 0; i < 8; i++) begin
            m = (i == 7) ? 8'h7f : 8'(i * 9);
            w = 32'hbff8_8008 | {1'b0, i[0], 11'h0, i[2:0], 1'b0, m[6:0],
                i[1], i[2:0], 1'b0, i[2:0]};
            if (i == 5) w[20] = 1'b0;
            rstn <= 1'b0;
            cfg_word_pins <= w;
            repeat (16) @(posedge clock);
            rstn <= 1'b1;
            for (int k = 0; k < 8 && cfg_valid !== 1'b1; k++) @(posedge clock);
            dv = (i == 0) ? 6'h02 : (i > 5) ? 6'h20 : 6'(6'h01 << i);
            chk("ready", cfg_valid, 1);
            chk("usb", usb_pll_ref_freq_select, i[0]);
            chk("div", sys_pll_output_divisor, dv);
            chk("mult", sys_pll_feedback_multiplier, m + 8'h01);
            chk("src", sys_pll_source_select, i[1]);
            chk("range", {cfg_range_reserved, sys_pll_input_range},
                {i > 5, i[2:0]});
            chk("rsvd", cfg_rsvd_bits_bad, i == 5);
            chk("idiv", sys_pll_input_divisor, i[2:0]);
            wb(1'b0, 8'h00);
            chk("word", {a, e, d}, {2'b10, w});
            wb(1'b0, 8'h04);
            chk("decoded", {a, e, d}, {2'b10, 8'h0, m + 8'h01, 2'b0, dv, 1'b0,
                i[2:0], 1'b0, i[2:0]});
            wb(1'b0, 8'h08);
            chk("status", {a, e, d}, {2'b10, 26'h0, i == 5, i > 5,
                i[1], i[0], 2'b01});
            wb(1'b1, 8'h00);
            chk("write", {a, e}, 2'b01);
            wb(1'b0, 8'h0c);
            chk("unmapped", {a, e, d}, {2'b01, 32'h0});
            cfg_word_pins <= ~w;
            repeat (4) @(posedge clock);
            wb(1'b0, 8'h00);
            chk("held", {d, sys_pll_feedback_multiplier}, {w, m + 8'h01});
        end
        end_sim();
    end
endmodule // pbcd_tb_top
